// file: core/clid_core.sv
// Instruction decoder and RAM access core of a character display controller.
`default_nettype none
`include "clid_defines.svh"
module clid_core (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic busStrobe,
  input wire logic register_select,
  input wire logic readNotWrite,
  input wire logic [7:0] busDataIn,
  output logic [7:0] busDataOut,
  output logic busy_flag,
  output logic [6:0] addr_counter,
  output logic glyphSelect,
  output logic entryIncrement,
  output logic entryShift,
  output logic displayOn,
  output logic cursorOn,
  output logic blinkOn,
  output logic bus_width,
  output logic twoLines,
  output logic bigFont,
  output logic [6:0] displayShift,
  output logic readValid
);
  localparam int LongCyc = `CLID_LONG_CYC;
  localparam int ShortCyc = `CLID_SHORT_CYC;
  clid_op_if opBus();
  clid_pkg::clid_state_t state_q;
  logic [7:0] text_ram [`CLID_TEXT_DEPTH];
  logic [7:0] glyph_ram [`CLID_GLYPH_DEPTH];
  logic [21:0] timer_q;
  logic [6:0] fill_q;
  logic readPrimed_q;
  wire logic accept = busStrobe && !busy_flag;
  wire logic instrWr = accept && !register_select && !readNotWrite;
  // Status reads bypass the busy gate so that the host can poll the busy flag.
  wire logic statusRd = busStrobe && !register_select && readNotWrite;
  wire logic dataWr = accept && register_select && !readNotWrite;
  wire logic dataRd = accept && register_select && readNotWrite;
  wire logic [6:0] acStep = entryIncrement ? 7'(addr_counter + 7'h01)
                                          : 7'(addr_counter - 7'h01);
  wire logic [6:0] glyphAc = {1'b0, addr_counter[5:0]};
  wire logic [7:0] ramByte = glyphSelect ? glyph_ram[glyphAc[5:0]] : text_ram[addr_counter];
  wire logic isClear = opBus.op == clid_pkg::CLID_OP_CLEAR;
  wire logic isLong = isClear || opBus.op == clid_pkg::CLID_OP_HOME;
  clid_decode decoder (
    .code(busDataIn),
    .dec(opBus)
  );
  // Busy sequencing: every accepted cycle that changes state holds busy for its bound.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= clid_pkg::CLID_IDLE;
      busy_flag <= 1'b0;
      timer_q <= '0;
      fill_q <= '0;
    end
    else
    begin
      case (state_q)
        clid_pkg::CLID_IDLE:
        begin
          if (instrWr && isClear)
          begin
            state_q <= clid_pkg::CLID_FILL;
            busy_flag <= 1'b1;
            fill_q <= '0;
            timer_q <= 22'(LongCyc - 1);
          end
          else if (instrWr || dataWr || dataRd)
          begin
            state_q <= clid_pkg::CLID_WAIT;
            busy_flag <= 1'b1;
            timer_q <= (instrWr && isLong) ? 22'(LongCyc - 1) : 22'(ShortCyc - 1);
          end
        end
        clid_pkg::CLID_FILL:
        begin
          fill_q <= 7'(fill_q + 7'h01);
          timer_q <= 22'(timer_q - 22'h000001);
          if (fill_q == 7'h7F)
          begin
            state_q <= clid_pkg::CLID_WAIT;
          end
        end
        clid_pkg::CLID_WAIT:
        begin
          if (timer_q == '0)
          begin
            state_q <= clid_pkg::CLID_IDLE;
            busy_flag <= 1'b0;
          end
          else
          begin
            timer_q <= 22'(timer_q - 22'h000001);
          end
        end
        default:
        begin
          state_q <= clid_pkg::CLID_IDLE;
          busy_flag <= 1'b0;
        end
      endcase
    end
  end
  // Memory arrays: the clear sequence writes spaces over text memory, one entry per cycle.
  always_ff @(posedge clk_sys)
  begin
    if (state_q == clid_pkg::CLID_FILL)
    begin
      text_ram[fill_q] <= `CLID_SPACE_CODE;
    end
    else if (dataWr && !glyphSelect)
    begin
      text_ram[addr_counter] <= busDataIn;
    end
    if (dataWr && glyphSelect)
    begin
      glyph_ram[glyphAc[5:0]] <= busDataIn;
    end
  end
  // Address counter, modes and read path.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      addr_counter <= '0;
      glyphSelect <= 1'b0;
      entryIncrement <= `CLID_RST_ENTRY_INC;
      entryShift <= 1'b0;
      displayOn <= 1'b0;
      cursorOn <= 1'b0;
      blinkOn <= 1'b0;
      bus_width <= 1'b1;
      twoLines <= 1'b0;
      bigFont <= 1'b0;
      displayShift <= '0;
      readPrimed_q <= 1'b0;
      busDataOut <= '0;
      readValid <= 1'b0;
    end
    else
    begin
      if (instrWr)
      begin
        case (opBus.op)
          clid_pkg::CLID_OP_CLEAR:
          begin
            addr_counter <= '0;
            glyphSelect <= 1'b0;
            displayShift <= '0;
            entryIncrement <= 1'b1;
            readPrimed_q <= 1'b1;
          end
          clid_pkg::CLID_OP_HOME:
          begin
            addr_counter <= '0;
            glyphSelect <= 1'b0;
            displayShift <= '0;
            readPrimed_q <= 1'b1;
          end
          clid_pkg::CLID_OP_ENTRY:
          begin
            entryIncrement <= opBus.arg[1];
            entryShift <= opBus.arg[0];
          end
          clid_pkg::CLID_OP_DISPLAY:
          begin
            displayOn <= opBus.arg[2];
            cursorOn <= opBus.arg[1];
            blinkOn <= opBus.arg[0];
          end
          clid_pkg::CLID_OP_SHIFT:
          begin
            if (opBus.arg[3])
            begin
              displayShift <= opBus.arg[2] ? 7'(displayShift + 7'h01)
                                           : 7'(displayShift - 7'h01);
            end
            else
            begin
              addr_counter <= opBus.arg[2] ? 7'(addr_counter + 7'h01)
                                           : 7'(addr_counter - 7'h01);
              readPrimed_q <= !glyphSelect;
            end
          end
          clid_pkg::CLID_OP_FUNC:
          begin
            bus_width <= opBus.arg[4];
            twoLines <= opBus.arg[3];
            bigFont <= opBus.arg[2];
          end
          clid_pkg::CLID_OP_GLYPH:
          begin
            addr_counter <= {1'b0, opBus.arg[5:0]};
            glyphSelect <= 1'b1;
            readPrimed_q <= 1'b1;
          end
          clid_pkg::CLID_OP_TEXT:
          begin
            addr_counter <= opBus.arg;
            glyphSelect <= 1'b0;
            readPrimed_q <= 1'b1;
          end
          default:
          begin
            readPrimed_q <= readPrimed_q;
          end
        endcase
      end
      else if (statusRd)
      begin
        busDataOut <= {busy_flag, addr_counter};
      end
      else if (dataWr)
      begin
        addr_counter <= glyphSelect ? {1'b0, acStep[5:0]} : acStep;
        readPrimed_q <= 1'b0;
        if (entryShift && !glyphSelect)
        begin
          displayShift <= entryIncrement ? 7'(displayShift - 7'h01)
                                         : 7'(displayShift + 7'h01);
        end
      end
      else if (dataRd)
      begin
        busDataOut <= ramByte;
        readValid <= readPrimed_q;
        readPrimed_q <= 1'b1;
        addr_counter <= glyphSelect ? {1'b0, acStep[5:0]} : acStep;
      end
    end
  end
endmodule
`default_nettype wire

// file: core/clid_defines.svh
// Constants of the character display instruction decoder.
`ifndef CLID_DEFINES_SVH
`define CLID_DEFINES_SVH
`define CLID_CLK_MHZ 200
`define CLID_OSC_KHZ 250
// Execution bounds at the reference oscillator, in ns, and cycles derived from them.
`define CLID_T_LONG_NS 15200000
`define CLID_T_SHORT_NS 40000
// Divide first so that the long bound does not overflow 32-bit integer arithmetic.
`define CLID_LONG_CYC ((`CLID_T_LONG_NS / 1000) * `CLID_CLK_MHZ)
`define CLID_SHORT_CYC ((`CLID_T_SHORT_NS / 1000) * `CLID_CLK_MHZ)
`define CLID_SPACE_CODE 8'h20
`define CLID_TEXT_DEPTH 128
`define CLID_GLYPH_DEPTH 64
`define CLID_RST_ENTRY_INC 1'b1
`endif

// file: core/clid_pkg.sv
// Types shared by the instruction decoder modules.
`default_nettype none
package clid_pkg;
  typedef enum logic [3:0] {
    CLID_OP_NONE, CLID_OP_CLEAR, CLID_OP_HOME, CLID_OP_ENTRY, CLID_OP_DISPLAY,
    CLID_OP_SHIFT, CLID_OP_FUNC, CLID_OP_GLYPH, CLID_OP_TEXT
  } clid_op_t;
  typedef enum logic [1:0] {CLID_IDLE, CLID_WAIT, CLID_FILL} clid_state_t;
endpackage
`default_nettype wire

// file: core/clid_op_if.sv
// Decoded instruction carried from the decoder to the core.
`default_nettype none
interface clid_op_if;
  clid_pkg::clid_op_t op;
  logic [6:0] arg;
  modport dec (output op, output arg);
  modport core (input op, input arg);
endinterface
`default_nettype wire

// file: core/clid_decode.sv
// Priority decoder of an instruction byte by its highest set bit.
`default_nettype none
module clid_decode (
  input wire logic [7:0] code,
  clid_op_if.dec dec
);
  assign dec.arg = code[6:0];
  // The highest set bit picks the instruction; lower bits are its arguments.
  assign dec.op = code[7] ? clid_pkg::CLID_OP_TEXT :
                  code[6] ? clid_pkg::CLID_OP_GLYPH :
                  code[5] ? clid_pkg::CLID_OP_FUNC :
                  code[4] ? clid_pkg::CLID_OP_SHIFT :
                  code[3] ? clid_pkg::CLID_OP_DISPLAY :
                  code[2] ? clid_pkg::CLID_OP_ENTRY :
                  code[1] ? clid_pkg::CLID_OP_HOME :
                  code[0] ? clid_pkg::CLID_OP_CLEAR : clid_pkg::CLID_OP_NONE;
endmodule
`default_nettype wire

// file: bench/clid_core_asserts.sv
// Port assertions of the instruction decoder core.
`default_nettype none
module clid_core_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic busStrobe,
  input wire logic register_select,
  input wire logic readNotWrite,
  input wire logic [7:0] busDataIn,
  input wire logic [7:0] busDataOut,
  input wire logic busy_flag,
  input wire logic [6:0] addr_counter,
  input wire logic glyphSelect,
  input wire logic entryIncrement,
  input wire logic entryShift,
  input wire logic displayOn,
  input wire logic cursorOn,
  input wire logic blinkOn,
  input wire logic [6:0] displayShift
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire take = busStrobe && !busy_flag;
  wire stat = busStrobe && !register_select && readNotWrite;
  wire ins = take && !register_select && !readNotWrite;
  wire rd = take && register_select && readNotWrite;
  a_busy_on_take: assert property (take && !stat |=> busy_flag)
    else $error("busy not raised");
  a_status_word: assert property (stat |=> busDataOut == {$past(busy_flag), $past(addr_counter)})
    else $error("status word wrong");
  a_text_addr: assert property (ins && busDataIn[7] |=> addr_counter == $past(busDataIn[6:0])
    && !glyphSelect)
    else $error("text address wrong");
  a_glyph_addr: assert property (ins && busDataIn[7:6] == 2'b01 |=>
    addr_counter == {1'b0, $past(busDataIn[5:0])} && glyphSelect)
    else $error("glyph address wrong");
  a_display_bits: assert property (ins && busDataIn[7:3] == 5'b00001 |=>
    {displayOn, cursorOn, blinkOn} == $past(busDataIn[2:0]))
    else $error("display bits wrong");
  a_entry_bits: assert property (ins && busDataIn[7:2] == 6'b000001 |=>
    {entryIncrement, entryShift} == $past(busDataIn[1:0]))
    else $error("entry bits wrong");
  a_clear_home: assert property (ins && busDataIn == 8'h01 |=> addr_counter == 7'h00
    && displayShift == 7'h00 && entryIncrement ##1 busy_flag [*8])
    else $error("clear result wrong");
  a_read_step: assert property (rd && entryIncrement && !glyphSelect |=>
    addr_counter == $past(addr_counter) + 7'h01 && $stable(displayShift))
    else $error("read step wrong");
  cover property (ins && busDataIn == 8'h01);
  cover property (rd);
  cover property (stat && busy_flag);
endmodule
bind clid_core clid_core_asserts i_clid_core_asserts (.clk_sys, .rst, .busStrobe,
  .register_select, .readNotWrite, .busDataIn, .busDataOut, .busy_flag, .addr_counter,
  .glyphSelect, .entryIncrement, .entryShift, .displayOn, .cursorOn, .blinkOn, .displayShift);
`default_nettype wire

// file: bench/clid_host.sv
// Host model that issues bus accesses to the decoder.
`default_nettype none
module clid_host (
  input wire logic clk_sys,
  input wire logic busy_flag,
  output var logic busStrobe = 1'b0,
  output var logic register_select = 1'b0,
  output var logic readNotWrite = 1'b0,
  output var logic [7:0] busDataIn = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic acc(input logic rs, input logic rw, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (busy_flag !== 1'b0 && !(rs == 1'b0 && rw == 1'b1) && n < 8500)
    begin
      @(negedge clk_sys);
      n++;
    end
    register_select = rs;
    readNotWrite = rw;
    busDataIn = d;
    busStrobe = 1'b1;
    @(negedge clk_sys);
    busStrobe = 1'b0;
    busDataIn = ~d;
  endtask
endmodule
`default_nettype wire

// file: bench/tb_clid_core.sv
// Self-checking bench of the instruction decoder core.
`default_nettype none
module tb_clid_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, busStrobe, register_select, readNotWrite, busy_flag, glyphSelect;
  logic entryIncrement, entryShift, displayOn, cursorOn, blinkOn, bus_width, twoLines;
  logic bigFont, readValid;
  logic [7:0] busDataIn, busDataOut;
  logic [6:0] addr_counter, displayShift;
  int err_total = 0;
  int num_checks = 0;
  `define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
    $display("CHECK FAILED %0t got %h want %h", $time, a, e); end end
  clid_core i_clid_core (.clk_sys, .rst, .busStrobe, .register_select, .readNotWrite,
    .busDataIn, .busDataOut, .busy_flag, .addr_counter, .glyphSelect, .entryIncrement,
    .entryShift, .displayOn, .cursorOn, .blinkOn, .bus_width, .twoLines, .bigFont,
    .displayShift, .readValid);
  clid_host i_clid_host (.clk_sys, .busy_flag, .busStrobe, .register_select, .readNotWrite,
    .busDataIn);
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic op(input logic [7:0] d);
    i_clid_host.acc(1'b0, 1'b0, d);
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #900000;
    err_total++;
    close_out();
  end
  initial
  begin
    rst = 1'b1;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    `CHK({entryIncrement, bus_width, busy_flag}, 3'b110)
    op(8'h85);
    `CHK(addr_counter, 7'h05)
    `CHK({glyphSelect, busy_flag}, 2'b01)
    i_clid_host.acc(1'b1, 1'b0, 8'h41);
    `CHK(addr_counter, 7'h06)
    op(8'h13);
    `CHK(addr_counter, 7'h05)
    i_clid_host.acc(1'b1, 1'b1, 8'h00);
    `CHK(busDataOut, 8'h41)
    `CHK(readValid, 1'b1)
    i_clid_host.acc(1'b1, 1'b1, 8'h00);
    `CHK({readValid, addr_counter}, 8'h87)
    i_clid_host.acc(1'b1, 1'b0, 8'h5A);
    i_clid_host.acc(1'b1, 1'b1, 8'h00);
    `CHK({readValid, addr_counter}, 8'h09)
    $display("test data done");
    // A reset ends the pending busy time early and keeps the run short.
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    op(8'h04);
    `CHK({entryIncrement, entryShift}, 2'b00)
    op(8'h0F);
    `CHK({displayOn, cursorOn, blinkOn}, 3'b111)
    op(8'h2F);
    `CHK({bus_width, twoLines, bigFont}, 3'b011)
    op(8'h7F);
    `CHK({glyphSelect, addr_counter}, 8'hBF)
    i_clid_host.acc(1'b0, 1'b1, 8'h00);
    `CHK(busDataOut, 8'hBF)
    $display("test modes done");
    op(8'h01);
    `CHK({entryIncrement, displayShift, addr_counter}, 15'h4000)
    repeat (300) @(negedge clk_sys);
    `CHK(busy_flag, 1'b1)
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    op(8'h8A);
    op(8'h1C);
    `CHK({displayShift !== 7'h00, addr_counter}, 8'h8A)
    op(8'h03);
    `CHK({displayShift, addr_counter}, 14'h0000)
    $display("test clear home done");
    close_out();
  end
endmodule
`default_nettype wire
